// >>> eeprom_array.sv
/*
  eeprom_array: the 512-word data store with its sixteen write latches.
  assumes: the controller sequences erase and program one word per cycle
  and supplies word and latch indices.
*/
`default_nettype none
module eeprom_array
(
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire logic                         lat_we,
  input  wire logic [nvm_pkg::LAT_IDX_W-1:0] lat_wr_idx,
  input  wire logic [15:0]                  lat_data,
  input  wire logic                         mem_we,
  input  wire logic                         mem_erase,
  input  wire logic [nvm_pkg::EE_IDX_W-1:0] mem_idx,
  input  wire logic [nvm_pkg::LAT_IDX_W-1:0] lat_rd_idx,
  input  wire logic [nvm_pkg::EE_IDX_W-1:0] rd_idx,
  output logic      [15:0]                  rd_data
);
  import nvm_pkg::*;

  logic [15:0] mem [EE_WORDS];
  logic [15:0] latch_reg [BLOCK_WORDS];

  // write latches load from table writes and start out erased
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < BLOCK_WORDS; i++)
        latch_reg[i] <= ERASED_WORD;
    end
    else if (lat_we)
      latch_reg[lat_wr_idx] <= lat_data;
  end

  // array cell update: erase writes all ones, program copies a latch
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_idx] <= mem_erase ? ERASED_WORD : latch_reg[lat_rd_idx];
  end

  // registered read port
  always_ff @(posedge mclk)
  begin
    if (srst)
      rd_data <= 16'h0000;
    else
      rd_data <= mem[rd_idx];
  end

endmodule
`default_nettype wire

// >>> nvm_pkg.sv
/*
  nvm_pkg: shared constants and carrier types for the non-volatile memory
  write/erase controller, its unlock sequencer and its data array.
  assumes: one processor clock; register offsets are byte addresses of the
  special-function register space.
*/
`default_nettype none
package nvm_pkg;

  // special-function register offsets
  localparam logic [15:0] OFS_CONTROL    = 16'h0760;
  localparam logic [15:0] OFS_ADDR_LOW   = 16'h0762;
  localparam logic [15:0] OFS_ADDR_UPPER = 16'h0764;
  localparam logic [15:0] OFS_UNLOCK_KEY = 16'h0766;

  // control register field positions and reset value
  localparam int          BIT_START   = 15;
  localparam int          BIT_PERMIT  = 14;
  localparam int          BIT_ABORTED = 13;
  localparam int          OPC_MSB     = 6;
  localparam int          OPC_ERASE   = 6;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST    = 16'h0000;

  // operation codes for the data array
  localparam logic [6:0] OPC_WORD_ERASE  = 7'h44;
  localparam logic [6:0] OPC_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OPC_WORD_PROG   = 7'h04;
  localparam logic [6:0] OPC_BLOCK_PROG  = 7'h0a;

  // unlock key values, carried in the low byte
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // data array geometry and its place in program space
  localparam int           EE_WORDS    = 512;
  localparam int           EE_IDX_W    = 9;
  localparam int           BLOCK_WORDS = 16;
  localparam int           LAT_IDX_W   = 4;
  localparam logic [23:0]  EE_FIRST    = 24'h7ffc00;
  localparam logic [23:0]  EE_LAST     = 24'h7ffffe;
  localparam logic [15:0]  ERASED_WORD = 16'hffff;

  // operation time
  localparam int OP_TIME_US  = 2000;
  localparam int CLK_MHZ     = 25;
  localparam int OP_CYCLES   = OP_TIME_US * CLK_MHZ;
  localparam int CNT_W       = 17;

  // one processor access to a special-function register
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfr_req_s;

  // one table instruction
  typedef struct packed {
    logic        rd;
    logic        wt;
    logic [23:0] ea;
    logic [15:0] wdata;
  } tbl_req_s;

endpackage
`default_nettype wire

// >>> nvm_write_erase_controller.sv
/*
  nvm_write_erase_controller: control, address and key registers of the
  non-volatile memory, the operation sequencer and the table access path
  to the data array.
  assumes: sfr and table strobes last one cycle on mclk; warm resets from
  the reset controller arrive as same-clock level inputs; the interrupt
  flag register clears the done flag through done_flag_clear.
*/
//
// Behaviour
// - start needs key writes 0x55 then 0xaa immediately before
// - control: start 15, permit 14, aborted 13, opcode 6..0, resets zero
// - data array of 512 words at 0x7ffc00 to 0x7ffffe
// - single-word and sixteen-word block erase and write supported; reads are single-word
// - location comes from upper and low address registers combined
// - write lasts about 2 ms; completion shown by status
// - data array operations run without stalling the processor
// - reads during an operation return unspecified data
// - software can set the start bit but never clear it
// - hardware clears the start bit when the operation ends
// - writes only with permit bit set; permit clear after power-up
// - warm reset during an operation sets the aborted flag
// - warm reset keeps the low address register for a retry
// - done flag set by hardware, cleared only by software
// - table read returns the addressed data array word
// - opcode 0x45 with permit erases the addressed block
// - key register is write-only, used only to arm starts
// - permit must be set by an earlier write than the start bit
// - low address captures bits 15..0 of each table address
// - program memory operations stall the processor until done
`default_nettype none
module nvm_write_erase_controller
#(
  parameter int unsigned OP_CYCLES = nvm_pkg::OP_CYCLES
)
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              master_clear_reset,
  input  wire logic              watchdog_timer_reset,
  input  wire nvm_pkg::sfr_req_s sfr_req,
  output logic        [15:0]     sfr_rdata,
  input  wire nvm_pkg::tbl_req_s tbl_req,
  output logic        [15:0]     tbl_rdata,
  input  wire logic              done_flag_clear,
  output logic                   done_irq_flag,
  output logic                   busy,
  output logic                   cpu_stall
);
  import nvm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_APPLY} op_e;

  localparam logic [CNT_W-1:0]     CNT_LAST  = CNT_W'(OP_CYCLES - 1);
  localparam logic [LAT_IDX_W-1:0] STEP_LAST = LAT_IDX_W'(BLOCK_WORDS - 1);

  op_e                  state_reg;
  logic                 start_reg;
  logic                 permit_reg;
  logic                 aborted_reg;
  logic [OPC_MSB:0]     opcode_reg;
  logic [15:0]          addr_low_reg;
  logic [6:0]           addr_upper_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [LAT_IDX_W-1:0] step_reg;
  logic                 op_ee_reg;
  logic                 op_block_reg;
  logic                 op_erase_reg;
  logic [EE_IDX_W-1:0]  op_idx_reg;
  logic                 tbl_ee_reg;
  logic [15:0]          sfr_rdata_next;

  logic                 warm_rst;
  logic                 armed;
  logic                 ctrl_wr;
  logic                 low_wr;
  logic                 upper_wr;
  logic                 start_req;
  logic                 start_ok;
  logic                 finish;
  logic [23:0]          target;
  logic                 target_ee;
  logic                 tbl_ee;
  logic                 opc_ee;
  logic                 mem_we;
  logic [EE_IDX_W-1:0]  mem_idx;
  logic [LAT_IDX_W-1:0] lat_rd_idx;
  logic [15:0]          array_rd;

  // register write decode
  assign warm_rst  = master_clear_reset || watchdog_timer_reset;
  assign ctrl_wr   = sfr_req.wr && (sfr_req.addr == OFS_CONTROL);
  assign low_wr    = sfr_req.wr && (sfr_req.addr == OFS_ADDR_LOW);
  assign upper_wr  = sfr_req.wr && (sfr_req.addr == OFS_ADDR_UPPER);

  // operation target from both address registers
  assign target    = {1'b0, addr_upper_reg, addr_low_reg};
  assign target_ee = (target >= EE_FIRST) && (target <= EE_LAST);
  assign tbl_ee    = (tbl_req.ea >= EE_FIRST) && (tbl_req.ea <= EE_LAST);
  assign opc_ee    = (opcode_reg == OPC_WORD_ERASE)  ||
                     (opcode_reg == OPC_BLOCK_ERASE) ||
                     (opcode_reg == OPC_WORD_PROG)   ||
                     (opcode_reg == OPC_BLOCK_PROG);

  // a start needs the key, an earlier permit and an idle sequencer
  assign start_req = ctrl_wr && sfr_req.wdata[BIT_START];
  assign start_ok  = start_req && armed && permit_reg &&
                     (state_reg == ST_IDLE) && !warm_rst;

  // the last array step, or the end of the wait for program memory
  assign finish    = ((state_reg == ST_APPLY) &&
                      (!op_block_reg || step_reg == STEP_LAST)) ||
                     ((state_reg == ST_WAIT) && cnt_reg == CNT_LAST &&
                      !op_ee_reg);

  assign busy      = start_reg;
  // only program memory work holds the processor
  assign cpu_stall = (state_reg != ST_IDLE) && !op_ee_reg;

  unlock_sequencer u_unlock
  (
    .mclk    (mclk),
    .srst    (srst || warm_rst),
    .sfr_req (sfr_req),
    .tbl_any (tbl_req.rd || tbl_req.wt),
    .armed   (armed)
  );

  // one array word per cycle: block ops walk the latches in order
  assign mem_we     = (state_reg == ST_APPLY);
  assign mem_idx    = op_block_reg ?
                      {op_idx_reg[EE_IDX_W-1:LAT_IDX_W], step_reg} :
                      op_idx_reg;
  assign lat_rd_idx = op_block_reg ? step_reg :
                      op_idx_reg[LAT_IDX_W-1:0];

  eeprom_array u_array
  (
    .mclk       (mclk),
    .srst       (srst),
    .lat_we     (tbl_req.wt && tbl_ee),
    .lat_wr_idx (tbl_req.ea[LAT_IDX_W:1]),
    .lat_data   (tbl_req.wdata),
    .mem_we     (mem_we),
    .mem_erase  (op_erase_reg),
    .mem_idx    (mem_idx),
    .lat_rd_idx (lat_rd_idx),
    .rd_idx     (tbl_req.ea[EE_IDX_W:1]),
    .rd_data    (array_rd)
  );

  // start bit: set by a keyed write, cleared only by hardware
  always_ff @(posedge mclk)
  begin
    if (srst || warm_rst)
      start_reg <= CONTROL_RST[BIT_START];
    else if (start_ok)
      start_reg <= 1'b1;
    else if (finish)
      start_reg <= 1'b0;
  end

  // permit bit follows software writes at any time; opcode follows them only while idle
  always_ff @(posedge mclk)
  begin
    if (srst || warm_rst)
    begin
      permit_reg <= CONTROL_RST[BIT_PERMIT];
      opcode_reg <= CONTROL_RST[OPC_MSB:0];
    end
    else if (ctrl_wr)
    begin
      permit_reg <= sfr_req.wdata[BIT_PERMIT];
      if (state_reg == ST_IDLE)
        opcode_reg <= sfr_req.wdata[OPC_MSB:0];
    end
  end

  // aborted flag: set by a warm reset mid-operation, survives it;
  // software may clear it, and the set wins in the same cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
      aborted_reg <= CONTROL_RST[BIT_ABORTED];
    else if (warm_rst && state_reg != ST_IDLE)
      aborted_reg <= 1'b1;
    else if (ctrl_wr && !sfr_req.wdata[BIT_ABORTED])
      aborted_reg <= 1'b0;
  end

  // low address: direct writes while idle and every table instruction; a warm
  // reset leaves it alone so the location can be retried
  always_ff @(posedge mclk)
  begin
    if (srst)
      addr_low_reg <= ADDR_RST;
    else if (tbl_req.rd || tbl_req.wt)
      addr_low_reg <= tbl_req.ea[15:0];
    else if (low_wr && state_reg == ST_IDLE)
      addr_low_reg <= sfr_req.wdata;
  end

  // upper address: seven bits above the low word
  always_ff @(posedge mclk)
  begin
    if (srst)
      addr_upper_reg <= ADDR_RST[6:0];
    else if (tbl_req.rd || tbl_req.wt)
      addr_upper_reg <= tbl_req.ea[22:16];
    else if (upper_wr && state_reg == ST_IDLE)
      addr_upper_reg <= sfr_req.wdata[6:0];
  end

  // operation sequencer: wait out the cell time, then touch the array
  always_ff @(posedge mclk)
  begin
    if (srst || warm_rst)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (start_ok)
            state_reg <= ST_WAIT;
        ST_WAIT:
          if (cnt_reg == CNT_LAST)
            state_reg <= op_ee_reg ? ST_APPLY : ST_IDLE;
        ST_APPLY:
          if (finish)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // operation parameters frozen at the start
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      op_ee_reg    <= 1'b0;
      op_block_reg <= 1'b0;
      op_erase_reg <= 1'b0;
      op_idx_reg   <= '0;
    end
    else if (start_ok)
    begin
      op_ee_reg    <= target_ee && opc_ee;
      op_block_reg <= (opcode_reg == OPC_BLOCK_ERASE) ||
                      (opcode_reg == OPC_BLOCK_PROG);
      op_erase_reg <= opcode_reg[OPC_ERASE];
      op_idx_reg   <= target[EE_IDX_W:1];
    end
  end

  // cell-time counter and block step counter
  always_ff @(posedge mclk)
  begin
    if (srst || state_reg == ST_IDLE)
    begin
      cnt_reg  <= '0;
      step_reg <= '0;
    end
    else if (state_reg == ST_WAIT)
      cnt_reg <= cnt_reg + 1'b1;
    else
      step_reg <= step_reg + 1'b1;
  end

  // done flag: hardware sets, software clears, set wins
  always_ff @(posedge mclk)
  begin
    if (srst)
      done_irq_flag <= 1'b0;
    else if (finish)
      done_irq_flag <= 1'b1;
    else if (done_flag_clear)
      done_irq_flag <= 1'b0;
  end

  // register read mux; the key register reads as zero
  always_comb
  begin
    sfr_rdata_next = 16'h0000;
    if (sfr_req.addr == OFS_CONTROL)
    begin
      sfr_rdata_next[BIT_START]   = start_reg;
      sfr_rdata_next[BIT_PERMIT]  = permit_reg;
      sfr_rdata_next[BIT_ABORTED] = aborted_reg;
      sfr_rdata_next[OPC_MSB:0]   = opcode_reg;
    end
    else if (sfr_req.addr == OFS_ADDR_LOW)
      sfr_rdata_next = addr_low_reg;
    else if (sfr_req.addr == OFS_ADDR_UPPER)
      sfr_rdata_next = {9'h000, addr_upper_reg};
    else if (sfr_req.addr == OFS_UNLOCK_KEY)
      sfr_rdata_next = 16'h0000;
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (srst)
      sfr_rdata <= 16'h0000;
    else if (sfr_req.rd)
      sfr_rdata <= sfr_rdata_next;
  end

  // table read answers with the array word when the address hits it;
  // during an operation the value is not guaranteed
  always_ff @(posedge mclk)
  begin
    if (srst)
      tbl_ee_reg <= 1'b0;
    else
      tbl_ee_reg <= tbl_req.rd && tbl_ee;
  end
  assign tbl_rdata = tbl_ee_reg ? array_rd : 16'h0000;

  a_start_unkeyed: assert property (@(posedge mclk) disable iff (srst)
    (start_req && !armed && !start_reg) |=> !start_reg)
    else $error("start accepted without key");

  a_same_write: assert property (@(posedge mclk) disable iff (srst)
    (start_req && sfr_req.wdata[BIT_PERMIT] && !permit_reg && !start_reg)
    |=> !start_reg)
    else $error("start and permit in one write started");

  a_start_sticky: assert property (@(posedge mclk) disable iff (srst)
    (start_reg && !finish && !warm_rst) |=> start_reg)
    else $error("start bit dropped early");

  a_done_clears: assert property (@(posedge mclk) disable iff (srst)
    finish |=> (!start_reg && done_irq_flag))
    else $error("finish did not clear start and set done");

  a_done_holds: assert property (@(posedge mclk) disable iff (srst)
    (done_irq_flag && !done_flag_clear) |=> done_irq_flag)
    else $error("done flag lost without clear");

  a_abort_flags: assert property (@(posedge mclk) disable iff (srst)
    (warm_rst && state_reg != ST_IDLE) |=>
    (aborted_reg && !start_reg && state_reg == ST_IDLE))
    else $error("abort not flagged");

  a_addr_kept: assert property (@(posedge mclk) disable iff (srst)
    (warm_rst && !tbl_req.rd && !tbl_req.wt && !low_wr) |=>
    $stable(addr_low_reg))
    else $error("low address changed by warm reset");

  a_wait_len: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == ST_WAIT && $past(state_reg) == ST_IDLE) |->
    cnt_reg == '0)
    else $error("wait counter not restarted");

  a_no_stall_ee: assert property (@(posedge mclk) disable iff (srst)
    (start_ok && target_ee && opc_ee) |=> busy && !cpu_stall)
    else $error("data array operation stalled processor");

  a_tbl_capture: assert property (@(posedge mclk) disable iff (srst)
    (tbl_req.rd || tbl_req.wt) |=>
    addr_low_reg == $past(tbl_req.ea[15:0]))
    else $error("table address not captured");

endmodule
`default_nettype wire

// >>> nvm_write_erase_controller_tb.sv
/*
  nvm_write_erase_controller_tb: self-checking bench for the controller,
  software model on the register and table side.
  assumes: nvm_pkg, the design and sw_host_model are compiled first.
*/
`default_nettype none
module nvm_write_erase_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_pkg::*;

  localparam int unsigned OPC_N = 20;

  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        master_clear_reset = 1'b0;
  logic        watchdog_timer_reset = 1'b0;
  logic        done_flag_clear = 1'b0;
  sfr_req_s    sfr_req;
  tbl_req_s    tbl_req;
  logic [15:0] sfr_rdata;
  logic [15:0] tbl_rdata;
  logic        done_irq_flag;
  logic        busy;
  logic        cpu_stall;
  int          n_fail = 0;
  int          total_checks = 0;
  int          seed = 32'h55d0;
  logic [15:0] pat [BLOCK_WORDS];
  logic [15:0] wv;
  logic [23:0] base;
  logic [23:0] ea;

  // 25 MHz processor clock
  always #20 mclk = ~mclk;

  nvm_write_erase_controller #(.OP_CYCLES(OPC_N)) dut
  (
    .mclk                 (mclk),
    .srst                 (srst),
    .master_clear_reset   (master_clear_reset),
    .watchdog_timer_reset (watchdog_timer_reset),
    .sfr_req              (sfr_req),
    .sfr_rdata            (sfr_rdata),
    .tbl_req              (tbl_req),
    .tbl_rdata            (tbl_rdata),
    .done_flag_clear      (done_flag_clear),
    .done_irq_flag        (done_irq_flag),
    .busy                 (busy),
    .cpu_stall            (cpu_stall)
  );

  sw_host_model host
  (
    .mclk      (mclk),
    .busy      (busy),
    .sfr_rdata (sfr_rdata),
    .tbl_rdata (tbl_rdata),
    .sfr_req   (sfr_req),
    .tbl_req   (tbl_req)
  );

  // control word expected from its fields
  function automatic logic [15:0] ctl(input logic s, input logic p,
                                      input logic e, input logic [6:0] o);
    return {s, p, e, 6'h00, o};
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.sfr_op(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [15:0] e);
    host.sfr_op(1'b0, a, 16'h0000);
    chk(nm, e, host.rd_val);
  endtask

  task automatic tbl_chk(input logic [23:0] a, input logic [15:0] e);
    host.tbl_op(1'b0, a, 16'h0000);
    chk("table word", e, host.rd_val);
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("control", OFS_CONTROL, CONTROL_RST);
    wr(OFS_UNLOCK_KEY, 16'h0055);
    rd_chk("key", OFS_UNLOCK_KEY, 16'h0000);
    base = EE_FIRST + 24'(($random(seed) & 31) * 32);
    wr(OFS_ADDR_LOW, base[15:0]);
    wr(OFS_ADDR_UPPER, {9'h000, base[22:16]});
    rd_chk("addr upper", OFS_ADDR_UPPER, {9'h000, base[22:16]});
    host.start_op(OPC_BLOCK_ERASE, 2'd0);
    chk1("busy", 1'b1, busy);
    chk1("stall", 1'b0, cpu_stall);
    wr(OFS_CONTROL, ctl(0, 1, 0, OPC_BLOCK_ERASE));
    rd_chk("start", OFS_CONTROL, ctl(1, 1, 0, OPC_BLOCK_ERASE));
    host.wait_idle();
    chk1("done", 1'b1, done_irq_flag);
    rd_chk("start", OFS_CONTROL, ctl(0, 1, 0, OPC_BLOCK_ERASE));
    repeat (5) @(posedge mclk);
    chk1("done held", 1'b1, done_irq_flag);
    done_flag_clear <= 1'b1;
    @(posedge mclk);
    done_flag_clear <= 1'b0;
    @(posedge mclk);
    #1 chk1("done clear", 1'b0, done_irq_flag);
    for (int i = 0; i < BLOCK_WORDS; i++)
      tbl_chk(base + 24'(2 * i), ERASED_WORD);
    for (int i = 0; i < BLOCK_WORDS; i++)
    begin
      pat[i] = 16'($random(seed));
      host.tbl_op(1'b1, base + 24'(2 * i), pat[i]);
    end
    rd_chk("addr low", OFS_ADDR_LOW, base[15:0] + 16'h001e);
    host.start_op(OPC_BLOCK_PROG, 2'd0);
    host.wait_idle();
    for (int i = 0; i < BLOCK_WORDS; i++)
      tbl_chk(base + 24'(2 * i), pat[i]);
    ea = base + 24'(($random(seed) & 15) * 2);
    wv = 16'($random(seed));
    host.tbl_op(1'b0, ea, 16'h0000);
    host.start_op(OPC_WORD_ERASE, 2'd0);
    host.wait_idle();
    tbl_chk(ea, ERASED_WORD);
    host.tbl_op(1'b1, ea, wv);
    host.start_op(OPC_WORD_PROG, 2'd0);
    host.wait_idle();
    tbl_chk(ea, wv);
    tbl_chk(ea ^ 24'h000002, pat[ea[4:1] ^ 4'h1]);
    tbl_chk(EE_FIRST - 24'h000002, 16'h0000);
    // starts without a proper key sequence or permit go nowhere
    for (int b = 1; b < 4; b++)
    begin
      host.start_op(OPC_WORD_PROG, 2'(b));
      chk1("refused", 1'b0, busy);
    end
    // warm resets in mid operation
    for (int k = 0; k < 2; k++)
    begin
      ea = base + 24'(4 * k);
      host.tbl_op(1'b0, ea, 16'h0000);
      host.start_op(OPC_WORD_PROG, 2'd0);
      master_clear_reset <= (k == 0);
      watchdog_timer_reset <= (k == 1);
      @(posedge mclk);
      master_clear_reset <= 1'b0;
      watchdog_timer_reset <= 1'b0;
      rd_chk("aborted", OFS_CONTROL, ctl(0, 0, 1, 7'h00));
      rd_chk("addr kept", OFS_ADDR_LOW, ea[15:0]);
      wr(OFS_CONTROL, 16'h0000);
    end
    // program memory operation stalls the processor
    host.start_op(7'h01, 2'd0);
    chk1("stall", 1'b1, cpu_stall);
    host.wait_idle();
    chk1("stall end", 1'b0, cpu_stall);
    chk1("finish", 1'b1, host.waited < 4000);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> sw_host_model.sv
/*
  sw_host_model: processor software facing the nvm controller; register
  and table strobes last one cycle, starts go through the key sequence.
  assumes: one clock mclk; the bench calls one task at a time.
*/
`default_nettype none
module sw_host_model
(
  input  wire logic              mclk,
  input  wire logic              busy,
  input  wire logic [15:0]       sfr_rdata,
  input  wire logic [15:0]       tbl_rdata,
  output var  nvm_pkg::sfr_req_s sfr_req,
  output var  nvm_pkg::tbl_req_s tbl_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_pkg::*;
  logic [15:0] rd_val;
  int          waited;

  // strobes idle from time zero
  initial
  begin
    sfr_req = '0;
    tbl_req = '0;
  end

  // register access; read data taken once it has landed
  task automatic sfr_op(input logic w, input logic [15:0] a,
                        input logic [15:0] d);
    @(posedge mclk);
    sfr_req <= '{w, !w, a, d};
    @(posedge mclk);
    sfr_req <= '0;
    @(posedge mclk);
    #1 rd_val = sfr_rdata;
  endtask

  // table access; read data stands one cycle only
  task automatic tbl_op(input logic w, input logic [23:0] a,
                        input logic [15:0] d);
    @(posedge mclk);
    tbl_req <= '{!w, w, a, d};
    @(posedge mclk);
    tbl_req <= '0;
    #1 rd_val = tbl_rdata;
  endtask

  // keyed start; brk 1 drops keys, 2 splits them, 3 permits too late
  task automatic start_op(input logic [6:0] opc, input logic [1:0] brk);
    sfr_op(1'b1, OFS_CONTROL, {1'b0, brk != 2'd3, 7'h00, opc});
    if (brk != 2'd1)
      sfr_op(1'b1, OFS_UNLOCK_KEY, {8'h00, KEY_FIRST});
    if (brk == 2'd2)
      sfr_op(1'b0, OFS_CONTROL, 16'h0000);
    if (brk != 2'd1)
      sfr_op(1'b1, OFS_UNLOCK_KEY, {8'h00, KEY_SECOND});
    sfr_op(1'b1, OFS_CONTROL, {2'b11, 7'h00, opc});
    repeat (2) @(posedge mclk);
  endtask

  // poll the start bit, bounded, before trusting data or going again
  task automatic wait_idle;
    waited = 0;
    while (busy !== 1'b0 && waited < 4000)
    begin
      // look after the edge has settled, not in its own time step
      @(posedge mclk);
      #1;
      waited++;
    end
    #1;
  endtask
endmodule
`default_nettype wire

// >>> unlock_sequencer.sv
/*
  unlock_sequencer: watches register traffic for the two-write key
  sequence and reports whether the next access may start an operation.
  assumes: requests are one-cycle strobes on the processor clock.
*/
`default_nettype none
module unlock_sequencer
(
  input  wire logic            mclk,
  input  wire logic            srst,
  input  wire nvm_pkg::sfr_req_s sfr_req,
  input  wire logic            tbl_any,
  output logic                 armed
);
  import nvm_pkg::*;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_e;

  key_e stage_reg;
  logic key_hit;
  logic any_acc;

  assign key_hit = sfr_req.wr && (sfr_req.addr == OFS_UNLOCK_KEY);
  assign any_acc = sfr_req.wr || sfr_req.rd || tbl_any;
  assign armed   = (stage_reg == KEY_ARMED);

  // each access advances or breaks the sequence; the armed state is
  // consumed by whatever access follows it
  always_ff @(posedge mclk)
  begin
    if (srst)
      stage_reg <= KEY_IDLE;
    else if (any_acc)
    begin
      if (key_hit && sfr_req.wdata[7:0] == KEY_FIRST)
        stage_reg <= KEY_HALF;
      else if (stage_reg == KEY_HALF && key_hit &&
               sfr_req.wdata[7:0] == KEY_SECOND)
        stage_reg <= KEY_ARMED;
      else
        stage_reg <= KEY_IDLE;
    end
  end

  a_key_arms: assert property (@(posedge mclk) disable iff (srst)
    (stage_reg == KEY_HALF && key_hit &&
     sfr_req.wdata[7:0] == KEY_SECOND) |=> armed)
    else $error("key pair did not arm");

  a_key_breaks: assert property (@(posedge mclk) disable iff (srst)
    (any_acc && !key_hit) |=> !armed)
    else $error("foreign access left unlock armed");

endmodule
`default_nettype wire
